// File: src/tic_pkg.sv
package tic_pkg;

  // ==========================================================================
  // Clock and time base
  // ==========================================================================
  localparam int CLK_HZ         = 25_000_000;
  localparam int MS_PER_S       = 1000;
  localparam int MS_CYCLES_DEF  = CLK_HZ / MS_PER_S;

  // ==========================================================================
  // Trigger timing, in milliseconds unless the name says otherwise
  // ==========================================================================
  localparam int  SAMPLE_MS      = 10;
  localparam int  RECHECK_MS     = 1;
  localparam int  RECHECK_COUNT  = 3;
  localparam int  MIN_LEVEL_MS   = 14;
  localparam int  MAX_LATENCY_MS = 15;
  localparam int  STEP_MAX_MS    = 800;
  localparam real RESET_MIN_S    = 1.0;
  localparam int  RESET_MIN_MS   = int'(RESET_MIN_S * MS_PER_S);

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int NUM_TRIG     = 2;
  localparam int ADDR_W       = 8;
  localparam int MS_CNT_W     = 16;
  localparam int SAMPLE_CNT_W = 4;
  localparam int CHK_CNT_W    = 2;
  localparam int HIGH_CNT_W   = 11;

  localparam logic [MS_CNT_W-1:0]     MS_CNT_RST     = 16'h0000;
  localparam logic [SAMPLE_CNT_W-1:0] SAMPLE_CNT_RST = 4'h0;
  localparam logic [SAMPLE_CNT_W-1:0] SAMPLE_LAST    = 4'(SAMPLE_MS - 1);
  localparam logic [CHK_CNT_W-1:0]    CHK_CNT_RST    = 2'h0;
  localparam logic [CHK_CNT_W-1:0]    CHK_LAST       = 2'(RECHECK_COUNT - 1);
  localparam logic [HIGH_CNT_W-1:0]   HIGH_CNT_RST   = 11'h000;
  localparam logic [HIGH_CNT_W-1:0]   HIGH_CNT_MAX   = 11'h7FF;
  localparam logic [HIGH_CNT_W-1:0]   STEP_LIMIT     = 11'(STEP_MAX_MS);
  localparam logic [HIGH_CNT_W-1:0]   RESET_LIMIT    = 11'(RESET_MIN_MS);
  localparam logic [ADDR_W-1:0]       ADDR_RST       = 8'h00;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    TIC_MODE_OFF,
    TIC_MODE_OUT,
    TIC_MODE_STEP
  } tic_mode_e;

  typedef enum logic {
    TIC_DB_IDLE,
    TIC_DB_CONFIRM
  } tic_db_e;

  typedef logic [ADDR_W-1:0] tic_addr_t;

endpackage

// File: src/tic_trig_if.sv
`timescale 1ns/10ps
interface tic_trig_if (
  input wire logic clk
);
  logic msTick;
  logic sampleTick;
  logic level;
  logic rise;
  logic fall;

  modport deb (
    input  msTick,
    input  sampleTick,
    output level,
    output rise,
    output fall
  );

  modport eval (
    output msTick,
    output sampleTick,
    input  level,
    input  rise,
    input  fall
  );
endinterface

// File: src/tic_debounce.sv
`timescale 1ns/10ps
module tic_debounce (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic pinIn,
  tic_trig_if.deb   trig
);
  import tic_pkg::*;

  // ==========================================================================
  // Pin synchroniser
  // ==========================================================================
  logic                 syncMeta;
  logic                 syncPin;
  tic_db_e              state;
  logic [CHK_CNT_W-1:0] chkCnt;
  logic                 stable;
  logic                 rise;
  logic                 fall;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      syncMeta <= 1'b0;
      syncPin  <= 1'b0;
    end else begin
      syncMeta <= pinIn;
      syncPin  <= syncMeta;
    end
  end

  // ==========================================================================
  // Sample and confirm
  // ==========================================================================
  // A change seen on the slow sample is only taken after it has held through
  // every recheck, so a bounce shorter than the recheck window never leaks out.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state  <= TIC_DB_IDLE;
      chkCnt <= CHK_CNT_RST;
      stable <= 1'b0;
      rise   <= 1'b0;
      fall   <= 1'b0;
    end else begin
      rise <= 1'b0;
      fall <= 1'b0;
      unique case (state)
        TIC_DB_IDLE: begin
          if (trig.sampleTick && (syncPin != stable)) begin
            state  <= TIC_DB_CONFIRM;
            chkCnt <= CHK_CNT_RST;
          end
        end
        TIC_DB_CONFIRM: begin
          if (trig.msTick) begin
            if (syncPin == stable) begin
              state <= TIC_DB_IDLE;
            end else if (chkCnt == CHK_LAST) begin
              state  <= TIC_DB_IDLE;
              stable <= syncPin;
              rise   <= syncPin;
              fall   <= ~syncPin;
            end else begin
              chkCnt <= chkCnt + 2'h1;
            end
          end
        end
      endcase
    end
  end

  assign trig.level = stable;
  assign trig.rise  = rise;
  assign trig.fall  = fall;

endmodule // tic_debounce

// File: src/tic_trigger_input_control.sv
`timescale 1ns/10ps
// Operation
// - Two trigger inputs exist and each one's function is picked by its own mode input.
// - Each input is sampled about every ten milliseconds.
// - A detected change is rechecked several times a millisecond apart and only taken if it holds.
// - The controlled function acts one to fifteen milliseconds after the input changes.
// - A channel in disabled mode ignores every level and edge.
// - In gating mode with the input low, the power output follows the panel and command requests unless the other input is gating it off.
// - In gating mode a rising edge switches the power output off.
// - In gating mode with the input high the output is held off and enable requests are refused.
// - In gating mode a falling edge switches the output on unless a temperature or voltage trip is active.
// - In step-recall mode the input steps through stored settings and a rising edge starts a pulse.
// - In step-recall mode a high pulse shorter than eight hundred milliseconds is a step trigger.
// - In step-recall mode a high pulse longer than one second resets the address counter to the start address.
// - A step falling edge recalls the current address and advances it, wrapping after the stop address; step edges on both inputs in one cycle count once.
module tic_trigger_input_control #(
  parameter int MS_CYCLES = tic_pkg::MS_CYCLES_DEF
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              firstTriggerInput,
  input  wire logic              secondTriggerInput,
  input  wire tic_pkg::tic_mode_e firstTriggerMode,
  input  wire tic_pkg::tic_mode_e secondTriggerMode,
  input  wire logic              outputOnRequest,
  input  wire logic              outputOffRequest,
  input  wire logic              overTempTrip,
  input  wire logic              overVoltageTrip,
  input  wire tic_pkg::tic_addr_t startAddr,
  input  wire tic_pkg::tic_addr_t stopAddr,
  output logic                   powerOutputOn,
  output logic                   outputOnRefused,
  output logic                   recallStrobe,
  output tic_pkg::tic_addr_t     recallAddr,
  output logic                   addrCounterReset,
  output logic [1:0]             triggerLevel
);
  import tic_pkg::*;

  localparam logic [MS_CNT_W-1:0] MS_LAST = MS_CNT_W'(MS_CYCLES - 1);

  // ==========================================================================
  // Millisecond and sample time base
  // ==========================================================================
  // One shared time base keeps both channels on the same sample grid; the
  // worst latency is one sample period plus the recheck window.
  logic [MS_CNT_W-1:0]     msCnt;
  logic                    msTick;
  logic [SAMPLE_CNT_W-1:0] sampleCnt;
  logic                    sampleTick;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      msCnt  <= MS_CNT_RST;
      msTick <= 1'b0;
    end else if (msCnt == MS_LAST) begin
      msCnt  <= MS_CNT_RST;
      msTick <= 1'b1;
    end else begin
      msCnt  <= msCnt + 16'h0001;
      msTick <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sampleCnt  <= SAMPLE_CNT_RST;
      sampleTick <= 1'b0;
    end else begin
      sampleTick <= 1'b0;
      if (msTick) begin
        if (sampleCnt == SAMPLE_LAST) begin
          sampleCnt  <= SAMPLE_CNT_RST;
          sampleTick <= 1'b1;
        end else begin
          sampleCnt <= sampleCnt + 4'h1;
        end
      end
    end
  end

  // ==========================================================================
  // Per-channel debounce and evaluation
  // ==========================================================================
  logic [NUM_TRIG-1:0] pins;
  tic_mode_e           modes [NUM_TRIG];
  logic [NUM_TRIG-1:0] gateHigh;
  logic [NUM_TRIG-1:0] gateOff;
  logic [NUM_TRIG-1:0] gateOn;
  logic [NUM_TRIG-1:0] stepEvt;
  logic [NUM_TRIG-1:0] longEvt;

  assign pins     = {secondTriggerInput, firstTriggerInput};
  assign modes[0] = firstTriggerMode;
  assign modes[1] = secondTriggerMode;

  for (genvar i = 0; i < NUM_TRIG; i++) begin : g_chan
    tic_trig_if trig (.clk(clk));

    logic                  isOut;
    logic                  isStep;
    logic [HIGH_CNT_W-1:0] highMs;
    logic                  longDone;

    assign trig.msTick     = msTick;
    assign trig.sampleTick = sampleTick;

    tic_debounce u_deb (
      .clk     (clk),
      .sys_rst (sys_rst),
      .pinIn   (pins[i]),
      .trig    (trig)
    );

    // Any illegal mode code behaves as disabled.
    assign isOut  = (modes[i] == TIC_MODE_OUT);
    assign isStep = (modes[i] == TIC_MODE_STEP);

    assign triggerLevel[i] = trig.level;
    assign gateHigh[i]     = isOut && trig.level;
    assign gateOff[i]      = isOut && trig.rise;
    assign gateOn[i]       = isOut && trig.fall;

    // Pulse length is measured on the debounced level, so it carries the
    // same few milliseconds of uncertainty as the edges themselves.
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        highMs <= HIGH_CNT_RST;
      end else if (trig.rise) begin
        highMs <= HIGH_CNT_RST;
      end else if (trig.level && msTick && (highMs != HIGH_CNT_MAX)) begin
        highMs <= highMs + 11'h001;
      end
    end

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        longDone <= 1'b0;
      end else if (trig.rise) begin
        longDone <= 1'b0;
      end else if (longEvt[i]) begin
        longDone <= 1'b1;
      end
    end

    // In the rise cycle the counter still holds the length of the last pulse, so that cycle never counts as long.
    assign longEvt[i] = isStep && trig.level && !trig.rise && !longDone && (highMs > RESET_LIMIT);
    assign stepEvt[i] = isStep && trig.fall && (highMs < STEP_LIMIT);
  end

  // ==========================================================================
  // Power output gating
  // ==========================================================================
  logic anyGateHigh;
  logic anyTrip;
  logic edgeOff;
  logic edgeOn;

  assign anyGateHigh = |gateHigh;
  assign anyTrip     = overTempTrip || overVoltageTrip;
  assign edgeOff     = |gateOff;
  assign edgeOn      = |gateOn;

  // Off sources win over on sources so the output can never be left on by a
  // request that lands in the same cycle as a lock-out.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      powerOutputOn <= 1'b0;
    end else if (edgeOff || anyGateHigh) begin
      powerOutputOn <= 1'b0;
    end else if (outputOffRequest) begin
      powerOutputOn <= 1'b0;
    end else if (edgeOn && !anyTrip) begin
      powerOutputOn <= 1'b1;
    end else if (outputOnRequest) begin
      powerOutputOn <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      outputOnRefused <= 1'b0;
    end else begin
      outputOnRefused <= outputOnRequest && (anyGateHigh || edgeOff);
    end
  end

  // ==========================================================================
  // Step recall address counter
  // ==========================================================================
  // The counter has no reset value tied to the start address, which is not a
  // constant; a pending-load flag makes the next step use the start address.
  tic_addr_t addrCnt;
  tic_addr_t curAddr;
  logic      needLoad;
  logic      anyStep;
  logic      anyLong;

  assign anyStep = |stepEvt;
  assign anyLong = |longEvt;
  assign curAddr = needLoad ? startAddr : addrCnt;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addrCnt  <= ADDR_RST;
      needLoad <= 1'b1;
    end else if (anyLong) begin
      addrCnt  <= ADDR_RST;
      needLoad <= 1'b1;
    end else if (anyStep) begin
      needLoad <= 1'b0;
      if (curAddr >= stopAddr) begin
        addrCnt <= startAddr;
      end else begin
        addrCnt <= curAddr + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      recallStrobe     <= 1'b0;
      recallAddr       <= ADDR_RST;
      addrCounterReset <= 1'b0;
    end else begin
      recallStrobe     <= anyStep && !anyLong;
      addrCounterReset <= anyLong;
      if (anyStep && !anyLong) begin
        recallAddr <= curAddr;
      end
    end
  end

endmodule // tic_trigger_input_control

// File: tb/tic_trigger_input_control_properties.sv
`timescale 1ns/10ps
// ==========================================================================
// Port checker
// ==========================================================================
module tic_trigger_input_control_properties (
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire tic_pkg::tic_mode_e firstTriggerMode,
  input wire tic_pkg::tic_mode_e secondTriggerMode,
  input wire logic               outputOnRequest,
  input wire logic               outputOffRequest,
  input wire logic               overTempTrip,
  input wire logic               overVoltageTrip,
  input wire tic_pkg::tic_addr_t startAddr,
  input wire tic_pkg::tic_addr_t stopAddr,
  input wire logic               powerOutputOn,
  input wire logic               outputOnRefused,
  input wire logic               recallStrobe,
  input wire tic_pkg::tic_addr_t recallAddr,
  input wire logic               addrCounterReset,
  input wire logic [1:0]         triggerLevel
);
  import tic_pkg::*;
  logic      gated;
  logic      afterRst;
  tic_addr_t lastAddr;
  assign gated = (firstTriggerMode == TIC_MODE_OUT && triggerLevel[0]) ||
                 (secondTriggerMode == TIC_MODE_OUT && triggerLevel[1]);
  // Both reset kinds leave the next step at the start address, so one flag serves them.
  always_ff @(posedge clk) begin
    if (sys_rst || addrCounterReset) afterRst <= 1'b1;
    else if (recallStrobe) afterRst <= 1'b0;
  end
  always_ff @(posedge clk) if (recallStrobe) lastAddr <= recallAddr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_gated2; gated [*2]; endsequence
  sequence s_fall1;
    $fell(triggerLevel[0]) ##0 (firstTriggerMode == TIC_MODE_OUT && !outputOffRequest && !triggerLevel[1]);
  endsequence
  property p_rise_off; $rose(triggerLevel[0]) && firstTriggerMode == TIC_MODE_OUT |=> !powerOutputOn; endproperty
  a_rise_off: assert property (p_rise_off) else $error("Output on after gate rise");
  property p_hold_off; s_gated2 |-> !powerOutputOn; endproperty
  a_hold_off: assert property (p_hold_off) else $error("Output on while gated");
  property p_refuse; outputOnRequest && gated |=> outputOnRefused; endproperty
  a_refuse: assert property (p_refuse) else $error("On request not refused");
  property p_fall_on; s_fall1 ##0 !(overTempTrip || overVoltageTrip) |=> powerOutputOn; endproperty
  a_fall_on: assert property (p_fall_on) else $error("Output off after gate fall");
  property p_fall_trip; s_fall1 ##0 ((overTempTrip || overVoltageTrip) && !outputOnRequest) |=> !powerOutputOn; endproperty
  a_fall_trip: assert property (p_fall_trip) else $error("Output on despite trip");
  property p_off_mode;
    firstTriggerMode == TIC_MODE_OFF && secondTriggerMode == TIC_MODE_OFF && !outputOnRequest && !outputOffRequest
      |=> $stable(powerOutputOn) && !recallStrobe && !addrCounterReset;
  endproperty
  a_off_mode: assert property (p_off_mode) else $error("Action from disabled input");
  property p_strobe_src;
    recallStrobe |-> ($past(triggerLevel[0], 2) && !$past(triggerLevel[0])) ||
                     ($past(triggerLevel[1], 2) && !$past(triggerLevel[1]));
  endproperty
  a_strobe_src: assert property (p_strobe_src) else $error("Recall without falling edge");
  property p_after_rst; recallStrobe && afterRst |-> recallAddr == startAddr; endproperty
  a_after_rst: assert property (p_after_rst) else $error("Recall not at start address");
  property p_step_next;
    recallStrobe && !afterRst |-> recallAddr == ((lastAddr >= stopAddr) ? startAddr : lastAddr + 8'h01);
  endproperty
  a_step_next: assert property (p_step_next) else $error("Recall address not advanced");
endmodule // tic_trigger_input_control_properties

// File: tb/tic_trigger_source.sv
`timescale 1ns/10ps
// ==========================================================================
// External trigger source
// ==========================================================================
module tic_trigger_source #(
  parameter int MS_CYCLES = 20
) (
  input  wire logic clk,
  input  wire logic reqLevel,
  input  wire logic glitch,
  output logic      pin
);
  import tic_pkg::*;
  int   held  = 0;
  logic level = 1'b0;
  // A level that changes too soon is not seen reliably, so requests wait out the hold time.
  always @(posedge clk) begin
    held <= held + 1;
    if (reqLevel != level && held >= MIN_LEVEL_MS * MS_CYCLES) begin
      level <= reqLevel;
      held  <= 0;
    end
  end
  assign pin = level ^ glitch;
endmodule // tic_trigger_source

// File: tb/tic_trigger_input_control_test.sv
`timescale 1ns/10ps
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin err_count++; \
  $display("Error %s expected %0h seen %0h", what, exp, got); end end
// ==========================================================================
// Testbench
// ==========================================================================
module tic_trigger_input_control_test;
  import tic_pkg::*;
  localparam int MSC = 20;
  logic       clk               = 1'b0;
  logic       sys_rst           = 1'b1;
  logic [1:0] reqLevel          = 2'h0;
  logic [1:0] glitch            = 2'h0;
  logic       firstTriggerInput;
  logic       secondTriggerInput;
  tic_mode_e  firstTriggerMode  = TIC_MODE_OFF;
  tic_mode_e  secondTriggerMode = TIC_MODE_OFF;
  logic       outputOnRequest   = 1'b0;
  logic       outputOffRequest  = 1'b0;
  logic       overTempTrip      = 1'b0;
  logic       overVoltageTrip   = 1'b0;
  tic_addr_t  startAddr         = 8'h00;
  tic_addr_t  stopAddr          = 8'h00;
  logic       powerOutputOn;
  logic       outputOnRefused;
  logic       recallStrobe;
  tic_addr_t  recallAddr;
  logic       addrCounterReset;
  logic [1:0] triggerLevel;
  tic_addr_t  seenAddr;
  tic_addr_t  expAddr;
  logic       refused;
  int         strobes           = 0;
  int         rstSeen           = 0;
  int         err_count         = 0;
  int         compares          = 0;
  int         cyc               = 0;
  tic_trigger_source #(.MS_CYCLES(MSC)) src0 (.clk, .reqLevel(reqLevel[0]), .glitch(glitch[0]), .pin(firstTriggerInput));
  tic_trigger_source #(.MS_CYCLES(MSC)) src1 (.clk, .reqLevel(reqLevel[1]), .glitch(glitch[1]), .pin(secondTriggerInput));
  tic_trigger_input_control #(.MS_CYCLES(MSC)) DUT (.clk, .sys_rst, .firstTriggerInput, .secondTriggerInput,
    .firstTriggerMode, .secondTriggerMode, .outputOnRequest, .outputOffRequest, .overTempTrip, .overVoltageTrip,
    .startAddr, .stopAddr, .powerOutputOn, .outputOnRefused, .recallStrobe, .recallAddr, .addrCounterReset,
    .triggerLevel);
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) cyc <= sys_rst ? 0 : cyc + 1;
  always @(posedge clk) begin
    if (recallStrobe === 1'b1) strobes++;
    if (recallStrobe === 1'b1) seenAddr = recallAddr;
    if (addrCounterReset === 1'b1) rstSeen++;
  end
  function automatic tic_addr_t next_addr(input tic_addr_t a);
    return (a >= stopAddr) ? startAddr : a + 8'h01;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic set_pin(input int ch, input logic lvl);
    int n;
    n = 0;
    reqLevel[ch] = lvl;
    while (((ch == 0) ? firstTriggerInput : secondTriggerInput) !== lvl && n < 30 * MSC) begin
      tick(1);
      n++;
    end
    n = 0;
    while (triggerLevel[ch] !== lvl && n < 20 * MSC) begin
      tick(1);
      n++;
    end
    `CHK("latency", 1'b1, n >= MSC && n <= MAX_LATENCY_MS * MSC + 4)
    tick(2);
  endtask
  task automatic request(input logic on);
    outputOnRequest = on;
    outputOffRequest = !on;
    tick(1);
    refused = outputOnRefused;
    outputOnRequest = 1'b0;
    outputOffRequest = 1'b0;
    tick(1);
  endtask
  task automatic final_report;
    $display("Compares %0d, errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    final_report;
  end
  initial begin
    void'($urandom(32'h873B));
    startAddr = 8'($urandom % 250);
    stopAddr = startAddr + 8'(1 + $urandom % 3);
    tick(16);
    sys_rst = 1'b0;
    set_pin(0, 1'b1);
    set_pin(0, 1'b0);
    `CHK("both disabled", 3'h3, {powerOutputOn, strobes == 0, rstSeen == 0})
    firstTriggerMode = TIC_MODE_OUT;
    request(1'b1);
    `CHK("output on", 1'b1, powerOutputOn)
    request(1'b0);
    `CHK("output off", 1'b0, powerOutputOn)
    request(1'b1);
    set_pin(0, 1'b1);
    `CHK("gate rise", 1'b0, powerOutputOn)
    request(1'b1);
    `CHK("on refused", 2'h1, {powerOutputOn, refused})
    // The glitch straddles a sample point, so only the recheck can reject it.
    while (cyc % (SAMPLE_MS * MSC) != SAMPLE_MS * MSC - 5) tick(1);
    glitch[0] = 1'b1;
    tick(10);
    glitch[0] = 1'b0;
    tick(20 * MSC);
    `CHK("glitch level", 1'b1, triggerLevel[0])
    {overTempTrip, overVoltageTrip} = 2'(1 + $urandom % 3);
    set_pin(0, 1'b0);
    `CHK("trip fall", 1'b0, powerOutputOn)
    {overTempTrip, overVoltageTrip} = 2'h0;
    set_pin(0, 1'b1);
    set_pin(0, 1'b0);
    `CHK("gate fall", 1'b1, powerOutputOn)
    set_pin(1, 1'b1);
    set_pin(1, 1'b0);
    `CHK("disabled input", 2'h3, {strobes == 0, powerOutputOn})
    secondTriggerMode = TIC_MODE_STEP;
    expAddr = startAddr;
    for (int i = 1; i <= 5; i++) begin
      set_pin(1, 1'b1);
      tick(($urandom % 100) * MSC);
      set_pin(1, 1'b0);
      `CHK("step count", i, strobes)
      `CHK("recall address", expAddr, seenAddr)
      expAddr = next_addr(expAddr);
    end
    set_pin(1, 1'b1);
    tick(1100 * MSC);
    `CHK("counter reset", 1, rstSeen)
    set_pin(1, 1'b0);
    set_pin(1, 1'b1);
    set_pin(1, 1'b0);
    `CHK("long pulse fall", 6, strobes)
    `CHK("restart address", startAddr, seenAddr)
    `CHK("gate untouched", 1'b1, powerOutputOn)
    final_report;
  end
endmodule // tic_trigger_input_control_test
bind tic_trigger_input_control tic_trigger_input_control_properties u_props (.clk, .sys_rst, .firstTriggerMode,
  .secondTriggerMode, .outputOnRequest, .outputOffRequest, .overTempTrip, .overVoltageTrip, .startAddr, .stopAddr,
  .powerOutputOn, .outputOnRefused, .recallStrobe, .recallAddr, .addrCounterReset, .triggerLevel);
